// ---- src/pcs_map.vh ----
// register offsets, reset values, keys and timing counts of the configuration port unit
// included by the configuration port design file; definitions only
`ifndef PCS_MAP_VH
`define PCS_MAP_VH
`define PCS_KEY_ENTER        8'h55
`define PCS_KEY_EXIT         8'hAA
`define PCS_IDX_LDSEL        8'h07
`define PCS_IDX_CFG_CTRL     8'h02
`define PCS_IDX_INDEX_ADDR   8'h03
`define PCS_IDX_DEV_ID       8'h20
`define PCS_IDX_DEV_REV      8'h21
`define PCS_IDX_PWR_CTRL     8'h22
`define PCS_IDX_PWR_MGMT     8'h23
`define PCS_IDX_OSC_CTRL     8'h24
`define PCS_IDX_PORT_LO      8'h26
`define PCS_IDX_PORT_HI      8'h27
`define PCS_IDX_CLK_MASK     8'h28
`define PCS_IDX_TEST_D       8'h2B
`define PCS_IDX_TEST_E       8'h2C
`define PCS_IDX_TEST_A       8'h2D
`define PCS_IDX_TEST_B       8'h2E
`define PCS_IDX_TEST_C       8'h2F
`define PCS_IDX_GLOBAL_TOP   8'h2F
`define PCS_IDX_ACTIVATE     8'h30
`define PCS_IDX_BASE_HI      8'h60
`define PCS_IDX_BASE_LO      8'h61
`define PCS_IDX_IRQ_SEL      8'h70
`define PCS_IDX_DMA_SEL      8'h74
`define PCS_IDX_FLP_MODE     8'hF0
`define PCS_IDX_FLP_OPTION   8'hF1
`define PCS_IDX_FLP_TYPE     8'hF2
`define PCS_IDX_FLP_DRV0     8'hF4
`define PCS_IDX_FLP_DRV1     8'hF5
`define PCS_LD_FLOPPY        8'h00
`define PCS_LD_PRINTER       8'h03
`define PCS_RST_INDEX_ADDR   8'h03
`define PCS_RST_OSC_CTRL     8'h04
`define PCS_RST_PORT_LO_S0   8'hF0
`define PCS_RST_PORT_LO_S1   8'h70
`define PCS_RST_PORT_HI      8'h03
`define PCS_RST_BASE_HI      8'h03
`define PCS_RST_BASE_LO      8'hF0
`define PCS_RST_IRQ_SEL      8'h06
`define PCS_RST_DMA_SEL      8'h02
`define PCS_RST_FLP_MODE     8'h0E
`define PCS_RST_FLP_TYPE     8'hFF
`define PCS_SOFT_RESET_BIT   0
`define PCS_BLOCK_TIME_NS    500000
`define PCS_CLOCK_PERIOD_NS  10
`define PCS_BLOCK_CYCLES     (`PCS_BLOCK_TIME_NS / `PCS_CLOCK_PERIOD_NS)
`endif

// ---- src/pcs_pin_sync.v ----
// three-stage synchroniser for a group of pins from outside the clock domain
// a change is taken once the second and third stages agree
`timescale 1ns/1ns
module pcs_pin_sync #(
   parameter WIDTH = 1
) (
   input  wire             i_clock,
   input  wire [WIDTH-1:0] i_pin,
   output reg  [WIDTH-1:0] o_level
);
   reg [WIDTH-1:0] s1_reg;
   reg [WIDTH-1:0] s2_reg;
   reg [WIDTH-1:0] s3_reg;
   genvar g;
   always @(posedge i_clock) begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : bit_filter
         // no reset: o_level follows the pins once both later stages agree
         always @(posedge i_clock) begin
            if (s2_reg[g] == s3_reg[g]) begin
               o_level[g] <= s3_reg[g];
            end
         end
      end
   endgenerate
endmodule

// ---- src/pcs_block_timer.v ----
// counts the host-access blocking window after a main supply power-on reset
// assumes i_start is a one-cycle or level request in the same clock domain
`timescale 1ns/1ns
module pcs_block_timer #(
   parameter CYCLES = 50000,
   parameter CW     = 17
) (
   input  wire i_clock,
   input  wire i_srst,
   input  wire i_start,
   output wire o_blocked
);
   reg [CW-1:0] count_reg;
   always @(posedge i_clock) begin
      if (i_srst) begin
         count_reg <= {CW{1'b0}};
      end else if (i_start) begin
         count_reg <= CYCLES[CW-1:0];
      end else if (count_reg != {CW{1'b0}}) begin
         count_reg <= count_reg - {{(CW-1){1'b0}}, 1'b1};
      end
   end
   assign o_blocked = (count_reg != {CW{1'b0}});
endmodule

// ---- src/pcs_config_port.v ----
// configuration key / index / data port unit with global and floppy unit registers
// assumes one host i/o cycle per i_io_wr or i_io_rd pulse, already qualified with aen
`timescale 1ns/1ns
`include "pcs_map.vh"

// Notes on behaviour
// - key 0x55 written at the key port enters configuration and opens index/data
// - key 0xAA written at the key port returns the device to run
// - only run and configuration states; run accepts only the entry key
// - in configuration, index sits at the key port, data at key port plus one
// - after an index write, data accesses reach that register of the selected device
// - global registers answer whatever logical device is selected
// - bit 0 of write-only index 0x02 soft resets registers with soft defaults
// - all host accesses ignored for 500 us after main power-on reset
// - host bus reset pin reloads every register but the factory test bytes with a hard default
// - identifier 0x20 and revision 0x21 are fixed and read only
// - floppy base resets to 0x03,0xF0, interrupt 0x06, dma 0x02
// - index and data decode only in configuration state
// - after hard or power-on reset: run state, all logical devices disabled
// - entering or leaving configuration leaves logical devices untouched
// - key port base latched from strap at reset, relocatable by two registers
module pcs_config_port #(
   parameter [7:0] DEVICE_IDENTIFIER    = 8'h5A,
   parameter [7:0] DEVICE_REV   = 8'h01,
   parameter       BLOCK_CYCLES = `PCS_BLOCK_CYCLES,
   parameter       BLOCK_CW     = 17
) (
   input  wire        i_clock,
   input  wire        i_srst,
   input  wire        i_main_por,
   input  wire        i_host_bus_reset_pin,
   input  wire        i_strap_port_sel,
   input  wire [15:0] i_io_addr,
   input  wire [7:0]  i_io_wdata,
   input  wire        i_io_wr,
   input  wire        i_io_rd,
   output reg  [7:0]  o_io_rdata,
   output reg         o_io_rd_hit,
   output wire        o_config_state,
   output wire        o_host_blocked,
   output wire [15:0] o_key_port_addr,
   output wire [7:0]  o_logical_device_select,
   output wire        o_floppy_active,
   output wire [15:0] o_floppy_base,
   output wire [7:0]  o_floppy_irq_select,
   output wire [7:0]  o_floppy_dma_select,
   output wire [7:0]  o_floppy_mode,
   output wire [7:0]  o_floppy_option,
   output wire [7:0]  o_floppy_type,
   output wire [7:0]  o_floppy_drive0_setup,
   output wire [7:0]  o_floppy_drive1_setup,
   output wire        o_printer_port_active,
   output wire [7:0]  o_power_control,
   output wire [7:0]  o_power_management,
   output wire [7:0]  o_oscillator_control,
   output wire [7:0]  o_clock_mask
);
   localparam [1:0] ST_RUN    = 2'b01;
   localparam [1:0] ST_CONFIG = 2'b10;

   function [39:0] test_defaults;
      input dummy;
      begin
         test_defaults = 40'h00_0000_0000;
      end
   endfunction

   wire       reset_pin_level;
   wire       strap_level;
   wire       host_blocked;
   reg        reset_pin_d_reg;
   reg  [1:0] settle_reg;
   reg        strap_take_reg;
   reg        hard_reset_reg;

   pcs_pin_sync #(
      .WIDTH (2)
   ) u_pin_sync (
      .i_clock (i_clock),
      .i_pin   ({i_strap_port_sel, i_host_bus_reset_pin}),
      .o_level ({strap_level, reset_pin_level})
   );

   pcs_block_timer #(
      .CYCLES (BLOCK_CYCLES),
      .CW     (BLOCK_CW)
   ) u_block_timer (
      .i_clock   (i_clock),
      .i_srst    (1'b0),
      .i_start   (i_srst | i_main_por),
      .o_blocked (host_blocked)
   );

   reg  [1:0]  state_reg;
   reg  [7:0]  index_reg;
   reg  [7:0]  index_addr_reg;
   reg  [7:0]  ldsel_reg;
   reg  [7:0]  pwr_ctrl_reg;
   reg  [7:0]  pwr_mgmt_reg;
   reg  [7:0]  osc_reg;
   reg  [7:0]  port_lo_reg;
   reg  [7:0]  port_hi_reg;
   reg  [7:0]  clk_mask_reg;
   reg  [39:0] test_reg;
   reg  [7:0]  flp_act_reg;
   reg  [7:0]  flp_base_hi_reg;
   reg  [7:0]  flp_base_lo_reg;
   reg  [7:0]  flp_irq_reg;
   reg  [7:0]  flp_dma_reg;
   reg  [7:0]  flp_mode_reg;
   reg  [7:0]  flp_option_reg;
   reg  [7:0]  flp_type_reg;
   reg  [7:0]  flp_drv0_reg;
   reg  [7:0]  flp_drv1_reg;
   reg  [7:0]  prt_act_reg;
   reg  [7:0]  rd_value;
   reg         rd_known;

   wire [15:0] key_port   = {port_hi_reg, port_lo_reg};
   wire        accept     = ~host_blocked & ~hard_reset_reg;
   wire        in_config  = (state_reg == ST_CONFIG);
   wire        at_key     = (i_io_addr == key_port);
   wire        at_data    = (i_io_addr == key_port + 16'h0001) & in_config;
   wire        key_wr     = accept & i_io_wr & at_key;
   wire        data_wr    = accept & i_io_wr & at_data;
   wire        data_rd    = accept & i_io_rd & at_data;
   wire        index_rd   = accept & i_io_rd & at_key & in_config;
   wire        global_idx = (index_reg <= `PCS_IDX_GLOBAL_TOP);
   wire        sel_flp    = (ldsel_reg == `PCS_LD_FLOPPY);
   wire        sel_prt    = (ldsel_reg == `PCS_LD_PRINTER);
   wire        soft_reset = data_wr & (index_reg == `PCS_IDX_CFG_CTRL)
                            & i_io_wdata[`PCS_SOFT_RESET_BIT];

   // the pin synchroniser has no reset: hold hard reset and take the strap once it has filled
   always @(posedge i_clock) begin
      if (i_srst) begin
         reset_pin_d_reg <= 1'b0;
         hard_reset_reg  <= 1'b1;
         strap_take_reg  <= 1'b0;
         settle_reg      <= 2'b11;
      end else begin
         settle_reg      <= {1'b0, settle_reg[1]};
         reset_pin_d_reg <= reset_pin_level;
         hard_reset_reg  <= (|settle_reg) | reset_pin_level | i_main_por;
         strap_take_reg  <= (settle_reg == 2'b01) | i_main_por
                            | (~|settle_reg & reset_pin_d_reg & ~reset_pin_level);
      end
   end

   // state: key port written in both states; index port shares its address
   always @(posedge i_clock) begin
      if (i_srst | hard_reset_reg) begin
         state_reg <= ST_RUN;
         index_reg <= 8'h00;
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (key_wr && i_io_wdata == `PCS_KEY_ENTER) begin
                  state_reg <= ST_CONFIG;
               end
               // every other run-state write is dropped
            end
            ST_CONFIG: begin
               if (key_wr && i_io_wdata == `PCS_KEY_EXIT) begin
                  state_reg <= ST_RUN;
               end else if (key_wr) begin
                  index_reg <= i_io_wdata;
               end
            end
            default: begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   // registers; the state change above never touches these, so devices run on
   always @(posedge i_clock) begin
      if (i_srst | hard_reset_reg) begin
         index_addr_reg  <= `PCS_RST_INDEX_ADDR;
         ldsel_reg       <= 8'h00;
         pwr_ctrl_reg    <= 8'h00;
         pwr_mgmt_reg    <= 8'h00;
         osc_reg         <= `PCS_RST_OSC_CTRL;
         clk_mask_reg    <= 8'h00;
         flp_act_reg     <= 8'h00;
         flp_base_hi_reg <= `PCS_RST_BASE_HI;
         flp_base_lo_reg <= `PCS_RST_BASE_LO;
         flp_irq_reg     <= `PCS_RST_IRQ_SEL;
         flp_dma_reg     <= `PCS_RST_DMA_SEL;
         flp_mode_reg    <= `PCS_RST_FLP_MODE;
         flp_option_reg  <= 8'h00;
         flp_type_reg    <= `PCS_RST_FLP_TYPE;
         flp_drv0_reg    <= 8'h00;
         flp_drv1_reg    <= 8'h00;
         prt_act_reg     <= 8'h00;
      end else if (soft_reset) begin
         ldsel_reg       <= 8'h00;
         pwr_ctrl_reg    <= 8'h00;
         clk_mask_reg    <= 8'h00;
         flp_act_reg     <= 8'h00;
         flp_base_hi_reg <= `PCS_RST_BASE_HI;
         flp_base_lo_reg <= `PCS_RST_BASE_LO;
         flp_irq_reg     <= `PCS_RST_IRQ_SEL;
         flp_dma_reg     <= `PCS_RST_DMA_SEL;
         prt_act_reg     <= 8'h00;
      end else if (data_wr && global_idx) begin
         if (index_reg == `PCS_IDX_INDEX_ADDR) begin
            index_addr_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_LDSEL) begin
            ldsel_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_PWR_CTRL) begin
            pwr_ctrl_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_PWR_MGMT) begin
            pwr_mgmt_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_OSC_CTRL) begin
            osc_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_CLK_MASK) begin
            clk_mask_reg <= i_io_wdata;
         end
      end else if (data_wr && sel_flp) begin
         if (index_reg == `PCS_IDX_ACTIVATE) begin
            flp_act_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_BASE_HI) begin
            flp_base_hi_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_BASE_LO) begin
            flp_base_lo_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_IRQ_SEL) begin
            flp_irq_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_DMA_SEL) begin
            flp_dma_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_FLP_MODE) begin
            flp_mode_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_FLP_OPTION) begin
            flp_option_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_FLP_TYPE) begin
            flp_type_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_FLP_DRV0) begin
            flp_drv0_reg <= i_io_wdata;
         end else if (index_reg == `PCS_IDX_FLP_DRV1) begin
            flp_drv1_reg <= i_io_wdata;
         end
      end else if (data_wr && sel_prt && index_reg == `PCS_IDX_ACTIVATE) begin
         prt_act_reg <= i_io_wdata;
      end
   end

   // key port address: strap default on reset release, host may move it afterwards
   always @(posedge i_clock) begin
      if (i_srst) begin
         port_lo_reg <= `PCS_RST_PORT_LO_S0;
         port_hi_reg <= `PCS_RST_PORT_HI;
      end else if (strap_take_reg) begin
         port_lo_reg <= strap_level ? `PCS_RST_PORT_LO_S1 : `PCS_RST_PORT_LO_S0;
         port_hi_reg <= `PCS_RST_PORT_HI;
      end else if (data_wr && index_reg == `PCS_IDX_PORT_LO) begin
         port_lo_reg <= i_io_wdata;
      end else if (data_wr && index_reg == `PCS_IDX_PORT_HI) begin
         port_hi_reg <= i_io_wdata;
      end
   end

   // factory test bytes load only on i_srst or the main power-on reset, not on the bus reset pin
   always @(posedge i_clock) begin
      if (i_srst | i_main_por) begin
         test_reg <= test_defaults(1'b0);
      end else if (data_wr && index_reg >= `PCS_IDX_TEST_D && index_reg <= `PCS_IDX_TEST_C) begin
         test_reg[(index_reg[2:0] - 3'd3) * 8 +: 8] <= i_io_wdata;
      end
   end

   // read mux; config control reads zero since it is write only
   always @* begin
      rd_value = 8'h00;
      rd_known = 1'b1;
      if (global_idx) begin
         if (index_reg == `PCS_IDX_INDEX_ADDR) begin
            rd_value = index_addr_reg;
         end else if (index_reg == `PCS_IDX_LDSEL) begin
            rd_value = ldsel_reg;
         end else if (index_reg == `PCS_IDX_DEV_ID) begin
            rd_value = DEVICE_IDENTIFIER;
         end else if (index_reg == `PCS_IDX_DEV_REV) begin
            rd_value = DEVICE_REV;
         end else if (index_reg == `PCS_IDX_PWR_CTRL) begin
            rd_value = pwr_ctrl_reg;
         end else if (index_reg == `PCS_IDX_PWR_MGMT) begin
            rd_value = pwr_mgmt_reg;
         end else if (index_reg == `PCS_IDX_OSC_CTRL) begin
            rd_value = osc_reg;
         end else if (index_reg == `PCS_IDX_PORT_LO) begin
            rd_value = port_lo_reg;
         end else if (index_reg == `PCS_IDX_PORT_HI) begin
            rd_value = port_hi_reg;
         end else if (index_reg == `PCS_IDX_CLK_MASK) begin
            rd_value = clk_mask_reg;
         end else if (index_reg >= `PCS_IDX_TEST_D) begin
            rd_value = test_reg[(index_reg[2:0] - 3'd3) * 8 +: 8];
         end
      end else if (sel_flp) begin
         if (index_reg == `PCS_IDX_ACTIVATE) begin
            rd_value = flp_act_reg;
         end else if (index_reg == `PCS_IDX_BASE_HI) begin
            rd_value = flp_base_hi_reg;
         end else if (index_reg == `PCS_IDX_BASE_LO) begin
            rd_value = flp_base_lo_reg;
         end else if (index_reg == `PCS_IDX_IRQ_SEL) begin
            rd_value = flp_irq_reg;
         end else if (index_reg == `PCS_IDX_DMA_SEL) begin
            rd_value = flp_dma_reg;
         end else if (index_reg == `PCS_IDX_FLP_MODE) begin
            rd_value = flp_mode_reg;
         end else if (index_reg == `PCS_IDX_FLP_OPTION) begin
            rd_value = flp_option_reg;
         end else if (index_reg == `PCS_IDX_FLP_TYPE) begin
            rd_value = flp_type_reg;
         end else if (index_reg == `PCS_IDX_FLP_DRV0) begin
            rd_value = flp_drv0_reg;
         end else if (index_reg == `PCS_IDX_FLP_DRV1) begin
            rd_value = flp_drv1_reg;
         end
      end else if (sel_prt && index_reg == `PCS_IDX_ACTIVATE) begin
         rd_value = prt_act_reg;
      end else begin
         rd_known = 1'b0;
      end
   end

   always @(posedge i_clock) begin
      if (i_srst) begin
         o_io_rdata  <= 8'h00;
         o_io_rd_hit <= 1'b0;
      end else begin
         o_io_rd_hit <= data_rd | index_rd;
         if (index_rd) begin
            o_io_rdata <= index_reg;
         end else if (data_rd) begin
            o_io_rdata <= rd_known ? rd_value : 8'h00;
         end
      end
   end

   assign o_config_state          = in_config;
   assign o_host_blocked          = host_blocked;
   assign o_key_port_addr         = key_port;
   assign o_logical_device_select = ldsel_reg;
   assign o_floppy_active         = flp_act_reg[0];
   assign o_floppy_base           = {flp_base_hi_reg, flp_base_lo_reg};
   assign o_floppy_irq_select     = flp_irq_reg;
   assign o_floppy_dma_select     = flp_dma_reg;
   assign o_floppy_mode           = flp_mode_reg;
   assign o_floppy_option         = flp_option_reg;
   assign o_floppy_type           = flp_type_reg;
   assign o_floppy_drive0_setup   = flp_drv0_reg;
   assign o_floppy_drive1_setup   = flp_drv1_reg;
   assign o_printer_port_active   = prt_act_reg[0];
   assign o_power_control         = pwr_ctrl_reg;
   assign o_power_management      = pwr_mgmt_reg;
   assign o_oscillator_control    = osc_reg;
   assign o_clock_mask            = clk_mask_reg;
endmodule

// ---- testbench/pcs_port_checker.sv ----
// concurrent checks on the configuration port unit
// bound to pcs_config_port; sees its ports only
`timescale 1ns/1ns
module pcs_port_checker #(
   parameter int BLOCK_CYCLES = 20
) (
   input logic        i_clock,
   input logic        i_srst,
   input logic        i_main_por,
   input logic        i_host_bus_reset_pin,
   input logic [15:0] i_io_addr,
   input logic [7:0]  i_io_wdata,
   input logic        i_io_wr,
   input logic        i_io_rd,
   input logic [7:0]  o_io_rdata,
   input logic        o_io_rd_hit,
   input logic        o_config_state,
   input logic        o_host_blocked,
   input logic [15:0] o_key_port_addr,
   input logic        o_floppy_active,
   input logic [15:0] o_floppy_base
);
   logic [3:0] quiet_reg;
   int         blk_reg;
   wire        key_hit = i_io_addr == o_key_port_addr;
   wire        data_hit = i_io_addr == o_key_port_addr + 16'h1;
   // the pin reset acts a few edges late through its synchroniser
   wire        ok = quiet_reg == 4'hF && !i_main_por && !o_host_blocked;
   always @(posedge i_clock) begin
      if (i_srst || i_host_bus_reset_pin)
         quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hF)
         quiet_reg <= quiet_reg + 4'h1;
      if (i_srst || i_main_por || !o_host_blocked)
         blk_reg <= 0;
      else
         blk_reg <= blk_reg + 1;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   enter_key_a: assert property (
      ok && !o_config_state && i_io_wr && key_hit && i_io_wdata == 8'h55 |=> o_config_state)
      else $error("entry key ignored");
   exit_key_a: assert property (
      ok && o_config_state && i_io_wr && key_hit && i_io_wdata == 8'hAA |=> !o_config_state)
      else $error("exit key ignored");
   run_other_a: assert property (
      ok && !o_config_state && i_io_wr && i_io_wdata != 8'h55 |=> !o_config_state)
      else $error("run state left without key");
   cfg_hold_a: assert property (
      ok && o_config_state && i_io_wr && key_hit && i_io_wdata != 8'hAA |=> o_config_state)
      else $error("index write left configuration");
   cfg_read_a: assert property (
      ok && o_config_state && i_io_rd && (key_hit || data_hit) |=> o_io_rd_hit)
      else $error("port read not decoded");
   run_read_a: assert property (
      ok && !o_config_state && i_io_rd |=> !o_io_rd_hit)
      else $error("read answered in run state");
   blk_ignore_a: assert property (
      o_host_blocked && !o_config_state && (i_io_wr || i_io_rd)
      |=> !o_config_state && !o_io_rd_hit)
      else $error("access taken while blocked");
   blk_hold_a: assert property (
      $fell(i_main_por) |-> ##1 o_host_blocked [*8])
      else $error("block window too short");
   blk_len_a: assert property (
      blk_reg <= BLOCK_CYCLES + 4)
      else $error("block window too long");
   rdata_hold_a: assert property (
      ok && !o_io_rd_hit |-> $stable(o_io_rdata))
      else $error("read data moved without a read");
   dev_steady_a: assert property (
      ok && i_io_wr && key_hit |=> $stable(o_floppy_active) && $stable(o_floppy_base))
      else $error("key port write disturbed a device");
endmodule

bind pcs_config_port pcs_port_checker #(.BLOCK_CYCLES(BLOCK_CYCLES)) u_chk (
   .i_clock(i_clock), .i_srst(i_srst), .i_main_por(i_main_por),
   .i_host_bus_reset_pin(i_host_bus_reset_pin), .i_io_addr(i_io_addr),
   .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_io_rdata(o_io_rdata),
   .o_io_rd_hit(o_io_rd_hit), .o_config_state(o_config_state),
   .o_host_blocked(o_host_blocked), .o_key_port_addr(o_key_port_addr),
   .o_floppy_active(o_floppy_active), .o_floppy_base(o_floppy_base));

// ---- testbench/pcs_host_model.sv ----
// host side model: single-cycle i/o writes and reads, one at a time
// tasks are called by the bench; all changes land just after a clock edge
`timescale 1ns/1ns
module pcs_host_model (
   input  logic        i_clock,
   input  logic [7:0]  i_io_rdata,
   input  logic        i_io_rd_hit,
   output logic [15:0] o_io_addr = 16'h0000,
   output logic [7:0]  o_io_wdata = 8'h00,
   output logic        o_io_wr = 1'b0,
   output logic        o_io_rd = 1'b0
);
   // a released bus shows the inverse of its last value, never a stale copy
   task automatic release_bus;
      o_io_wr <= 1'b0;
      o_io_rd <= 1'b0;
      o_io_addr <= ~o_io_addr;
      o_io_wdata <= ~o_io_wdata;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clock);
      o_io_addr <= a;
      o_io_wdata <= d;
      o_io_wr <= 1'b1;
      @(posedge i_clock);
      release_bus();
      #1;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic h);
      @(posedge i_clock);
      o_io_addr <= a;
      o_io_rd <= 1'b1;
      @(posedge i_clock);
      release_bus();
      #1;
      d = i_io_rdata;
      h = i_io_rd_hit;
   endtask
endmodule

// ---- testbench/pcs_config_port_test.sv ----
// self-checking bench for the configuration port unit
// short block window; host cycles come from the host model
`timescale 1ns/1ns
module pcs_config_port_test;
   logic        i_clock = 1'b0;
   logic        i_srst = 1'b1;
   logic        por = 1'b0, pin = 1'b0, strap = 1'b0;
   logic [15:0] addr, key, kp, fbase;
   logic [7:0]  wdata, rdata, ldsel, irq, pmgmt, dma, fmode, fopt, ftype, drv0, drv1;
   logic [7:0]  pctl, osc, cmask;
   logic        wr, rd, hit, cfg, blocked, fact, pact;
   int          n_fail = 0, checks_done = 0;
   always #5 i_clock = ~i_clock;
   // identifier and revision values are arbitrary
   pcs_config_port #(.DEVICE_IDENTIFIER(8'h5A), .DEVICE_REV(8'h01), .BLOCK_CYCLES(20)) uut (
      .i_clock(i_clock), .i_srst(i_srst), .i_main_por(por), .i_host_bus_reset_pin(pin),
      .i_strap_port_sel(strap), .i_io_addr(addr), .i_io_wdata(wdata), .i_io_wr(wr),
      .i_io_rd(rd), .o_io_rdata(rdata), .o_io_rd_hit(hit), .o_config_state(cfg),
      .o_host_blocked(blocked), .o_key_port_addr(key), .o_logical_device_select(ldsel),
      .o_floppy_active(fact), .o_floppy_base(fbase), .o_floppy_irq_select(irq),
      .o_floppy_dma_select(dma), .o_floppy_mode(fmode), .o_floppy_option(fopt),
      .o_floppy_type(ftype), .o_floppy_drive0_setup(drv0), .o_floppy_drive1_setup(drv1),
      .o_printer_port_active(pact), .o_power_control(pctl), .o_power_management(pmgmt),
      .o_oscillator_control(osc), .o_clock_mask(cmask));
   pcs_host_model host (.i_clock(i_clock), .i_io_rdata(rdata), .i_io_rd_hit(hit),
      .o_io_addr(addr), .o_io_wdata(wdata), .o_io_wr(wr), .o_io_rd(rd));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cw(input logic [7:0] idx, input logic [7:0] val);
      host.wr(kp, idx);
      host.wr(kp + 16'h1, val);
   endtask
   task automatic cr(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      logic       h;
      host.wr(kp, idx);
      host.rd(kp + 16'h1, d, h);
      chk({h, d}, {1'b1, exp});
   endtask
   task automatic wait_free;
      int k;
      k = 0;
      while (blocked !== 1'b0 && k < 100) begin
         @(posedge i_clock);
         #1;
         k++;
      end
      chk(blocked, 1'b0);
   endtask
   task automatic t_keys;
      logic [7:0] d;
      logic       h;
      host.wr(kp, 8'h12);
      chk(cfg, 1'b0);
      host.rd(kp + 16'h1, d, h);
      chk(h, 1'b0);
      host.wr(kp, 8'h55);
      chk(cfg, 1'b1);
      host.wr(kp, 8'hAA);
      chk(cfg, 1'b0);
      host.wr(kp, 8'h55);
      chk(cfg, 1'b1);
   endtask
   task automatic t_defaults;
      logic [15:0] t [0:21] = '{16'h0200, 16'h0303, 16'h0700, 16'h205A, 16'h2101,
         16'h2200, 16'h2300, 16'h2404, 16'h26F0, 16'h2703, 16'h2800, 16'h2B00,
         16'h3000, 16'h6003, 16'h61F0, 16'h7006, 16'h7402, 16'hF00E, 16'hF100,
         16'hF2FF, 16'hF400, 16'hF500};
      chk({fact, pact}, 2'b00);
      cw(8'h07, 8'h00);
      foreach (t[i])
         cr(t[i][15:8], t[i][7:0]);
      chk({dma, fmode, ftype}, 24'h020EFF);
      chk({fopt, drv0, drv1}, 24'h000000);
      chk({pctl, osc, cmask}, 24'h000400);
   endtask
   task automatic t_access;
      cw(8'h20, 8'hFF);
      cr(8'h20, 8'h5A);
      cw(8'h70, 8'h0B);
      chk(irq, 8'h0B);
      cw(8'h23, 8'h05);
      cw(8'h2B, 8'h11);
      cw(8'h30, 8'h01);
      cw(8'h07, 8'h03);
      cr(8'h70, 8'h00);
      cr(8'h23, 8'h05);
      cw(8'h30, 8'h01);
      chk(pact, 1'b1);
      cw(8'h07, 8'h01);
      cw(8'h30, 8'h01);
      cr(8'h30, 8'h00);
      host.wr(kp, 8'hAA);
      chk({cfg, fact, pact}, 3'b011);
      host.wr(kp, 8'h55);
      chk({cfg, ldsel}, 9'h101);
   endtask
   task automatic t_soft;
      cw(8'h02, 8'h01);
      chk({fact, pact, ldsel, irq}, 18'h00006);
      chk(pmgmt, 8'h05);
      cr(8'h02, 8'h00);
   endtask
   task automatic t_hard;
      @(posedge i_clock);
      pin <= 1'b1;
      strap <= 1'b1;
      repeat (4) @(posedge i_clock);
      pin <= 1'b0;
      repeat (12) @(posedge i_clock);
      #1;
      chk({cfg, fact, pact, fbase}, 19'h003F0);
      chk(key, 16'h0370);
      kp = 16'h0370;
      host.wr(kp, 8'h55);
      cr(8'h2B, 8'h11);
      cr(8'h26, 8'h70);
      cw(8'h26, 8'hF0);
      kp = 16'h03F0;
      chk(key, kp);
      host.wr(kp, 8'hAA);
      chk(cfg, 1'b0);
   endtask
   task automatic t_por;
      @(posedge i_clock);
      por <= 1'b1;
      repeat (2) @(posedge i_clock);
      por <= 1'b0;
      kp = 16'h0370;
      host.wr(kp, 8'h55);
      chk(cfg, 1'b0);
      wait_free();
      host.wr(kp, 8'h55);
      cr(8'h2B, 8'h00);
      host.wr(kp, 8'hAA);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      kp = 16'h03F0;
      repeat (3) @(posedge i_clock);
      i_srst <= 1'b0;
      wait_free();
      t_keys();
      t_defaults();
      t_access();
      t_soft();
      t_hard();
      t_por();
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      n_fail++;
      end_of_test();
   end
endmodule
